// File: logic/drive_map_pkg.sv
// Constants and carrier types for the drive fieldbus data map
package drive_map_pkg;

  // Wire addresses are item number minus one
  localparam logic [15:0] COIL_CTW_LO = 16'h0000;
  localparam logic [15:0] COIL_REF_LO = 16'h0010;
  localparam logic [15:0] COIL_STW_LO = 16'h0020;
  localparam logic [15:0] COIL_MAV_LO = 16'h0030;
  localparam logic [15:0] COIL_STORE = 16'h0040;
  localparam logic [16:0] COIL_COUNT = 17'h00041;
  localparam logic [4:0] COIL_MAX_QTY = 5'h10;

  // Holding register numbers as printed; the wire address drops one
  localparam logic [16:0] HR_ERR_NUM = 17'h00007;
  localparam logic [16:0] HR_INDEX_NUM = 17'h00009;
  localparam logic [16:0] HR_CTW_NUM = 17'h0C350;
  localparam logic [16:0] HR_REF_NUM = 17'h0C35A;
  localparam logic [16:0] HR_STW_NUM = 17'h0C418;
  localparam logic [16:0] HR_MAV_NUM = 17'h0C422;
  localparam logic [16:0] HR_PARAM_FIRST = 17'h0000A;
  localparam logic [16:0] HR_PARAM_LAST = 17'h0C346;
  localparam logic [16:0] HR_PARAM_STEP = 17'h0000A;

  // Reset values
  localparam logic [15:0] CTW_RESET = 16'h0000;
  localparam logic [15:0] REF_RESET = 16'h0000;
  localparam logic [15:0] INDEX_RESET = 16'h0000;
  localparam logic [7:0] ERR_RESET = 8'h00;

  // Error code given for an unmapped or read-only item
  localparam logic [7:0] ERR_INVALID_ADDR = 8'h40;

  // Status word field positions
  localparam int STW_CTRL_READY = 0;
  localparam int STW_DRIVE_READY = 1;
  localparam int STW_SAFETY = 2;
  localparam int STW_ALARM = 3;
  localparam int STW_WARNING = 7;
  localparam int STW_AT_REF = 8;
  localparam int STW_AUTO = 9;
  localparam int STW_IN_RANGE = 10;
  localparam int STW_RUNNING = 11;
  localparam int STW_VOLT_WARN = 13;
  localparam int STW_CURR_LIMIT = 14;
  localparam int STW_THERMAL = 15;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PARAM = 2'b01,
    ST_WAIT = 2'b10
  } state_type;

  typedef struct packed {
    logic valid;
    logic holding;
    logic write;
    logic [15:0] addr;
    logic [4:0] count;
    logic [15:0] wdata;
  } map_req_type;

  typedef struct packed {
    logic valid;
    logic exception;
    logic [7:0] code;
    logic [15:0] data;
  } map_rsp_type;

  typedef struct packed {
    logic valid;
    logic write;
    logic to_nvm;
    logic [12:0] number;
    logic [15:0] index;
    logic [15:0] wdata;
  } param_req_type;

  typedef struct packed {
    logic done;
    logic error;
    logic [7:0] code;
    logic [15:0] rdata;
  } param_rsp_type;

  typedef struct packed {
    logic ctrl_ready;
    logic drive_ready;
    logic safety_closed;
    logic alarm;
    logic warning;
    logic at_reference;
    logic auto_mode;
    logic in_freq_range;
    logic running;
    logic voltage_warning;
    logic current_limit;
    logic thermal_warning;
  } drive_state_type;

  typedef struct packed {
    logic [1:0] preset_ref;
    logic dc_brake;
    logic coast_stop;
    logic quick_stop;
    logic freeze_freq;
    logic start;
    logic reset;
    logic jog;
    logic ramp2;
    logic data_valid;
    logic relay1_on;
    logic relay2_on;
    logic [1:0] setup_sel;
    logic reversing;
  } drive_cmd_type;

endpackage : drive_map_pkg

// File: logic/drive_fieldbus_data_map.sv
// Coil and holding register data map of the drive's fieldbus slave
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////

module drive_fieldbus_data_map (
  input wire logic clk_sys,
  input wire logic rst,
  input wire drive_map_pkg::map_req_type map_req,
  output logic map_req_ready,
  output drive_map_pkg::map_rsp_type map_rsp,
  output drive_map_pkg::param_req_type param_req,
  input wire drive_map_pkg::param_rsp_type param_rsp,
  input wire drive_map_pkg::drive_state_type drive_state,
  input wire logic closed_loop,
  input wire logic [15:0] output_freq,
  input wire logic [15:0] feedback_value,
  output drive_map_pkg::drive_cmd_type drive_cmd,
  output logic [15:0] bus_reference,
  output logic store_to_nvm
);
  import drive_map_pkg::*;

  typedef struct packed {
    state_type state;
    logic [15:0] drive_control_word;
    logic [15:0] ref_val;
    logic store;
    logic [15:0] index;
    logic [7:0] err;
    map_rsp_type rsp;
    param_req_type preq;
  } map_state_type;

  map_state_type cur_ff;
  map_state_type nxt_cur;

  //////////////////////////////////////////////////////////////////////////////

  function automatic logic [16:0] wire_of(input logic [16:0] number);
    wire_of = number - 17'h00001;
  endfunction : wire_of

  function automatic logic [15:0] status_word(input drive_state_type s);
    logic [15:0] w;
    w = 16'h0000;
    w[STW_CTRL_READY] = s.ctrl_ready;
    w[STW_DRIVE_READY] = s.drive_ready;
    w[STW_SAFETY] = s.safety_closed;
    w[STW_ALARM] = s.alarm;
    w[STW_WARNING] = s.warning;
    w[STW_AT_REF] = s.at_reference;
    w[STW_AUTO] = s.auto_mode;
    w[STW_IN_RANGE] = s.in_freq_range;
    w[STW_RUNNING] = s.running;
    w[STW_VOLT_WARN] = s.voltage_warning;
    w[STW_CURR_LIMIT] = s.current_limit;
    w[STW_THERMAL] = s.thermal_warning;
    status_word = w;
  endfunction : status_word

  //////////////////////////////////////////////////////////////////////////////

  logic [15:0] stw_word;
  logic [15:0] mav_word;
  logic [64:0] coil_vec;
  logic [16:0] req_num;
  logic [16:0] req_end;
  logic coil_in_range;
  logic coil_hits_ro;
  logic [64:0] coil_shift;
  logic [64:0] coil_wvec;
  logic [16:0] param_off;
  logic param_hit;

  assign stw_word = status_word(drive_state);
  assign mav_word = closed_loop ? feedback_value : output_freq;
  // One bit per coil, wire address equals bit position
  assign coil_vec = {cur_ff.store, mav_word, stw_word, cur_ff.ref_val,
                     cur_ff.drive_control_word};
  assign req_num = {1'b0, map_req.addr} + 17'h00001;
  assign req_end = {1'b0, map_req.addr} + {12'h000, map_req.count};
  assign coil_in_range = (map_req.count != 5'h00) &&
                         (map_req.count <= COIL_MAX_QTY) &&
                         (req_end <= COIL_COUNT);
  // Status and actual value coils are slave-to-master only
  assign coil_hits_ro = ({1'b0, map_req.addr} < wire_of(COIL_COUNT)) &&
                        (req_end > {1'b0, COIL_STW_LO});
  assign coil_shift = coil_vec >> map_req.addr;
  assign param_off = req_num - HR_PARAM_FIRST;
  assign param_hit = (req_num >= HR_PARAM_FIRST) &&
                     (req_num <= HR_PARAM_LAST) &&
                     ((req_num % HR_PARAM_STEP) == 17'h00000);

  always_comb
  begin
    coil_wvec = coil_vec;
    for (int i = 0; i < 16; i++)
    begin
      if ((i < int'(map_req.count)) && (int'(map_req.addr) + i < 65))
      begin
        coil_wvec[int'(map_req.addr) + i] = map_req.wdata[i];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  always_comb
  begin
    nxt_cur = cur_ff;
    nxt_cur.rsp.valid = 1'b0;
    nxt_cur.preq.valid = 1'b0;
    case (cur_ff.state)
      ST_IDLE:
      begin
        if (map_req.valid)
        begin
          nxt_cur.rsp.valid = 1'b1;
          nxt_cur.rsp.exception = 1'b0;
          nxt_cur.rsp.code = 8'h00;
          nxt_cur.rsp.data = 16'h0000;
          if (!map_req.holding)
          begin
            if (!coil_in_range || (map_req.write && coil_hits_ro))
            begin
              nxt_cur.rsp.exception = 1'b1;
              nxt_cur.rsp.code = ERR_INVALID_ADDR;
              nxt_cur.err = ERR_INVALID_ADDR;
            end
            else if (map_req.write)
            begin
              nxt_cur.drive_control_word = coil_wvec[15:0];
              nxt_cur.ref_val = coil_wvec[31:16];
              nxt_cur.store = coil_wvec[64];
            end
            else
            begin
              // Coils past the quantity read as zero padding
              for (int i = 0; i < 16; i++)
              begin
                nxt_cur.rsp.data[i] = (i < int'(map_req.count)) ?
                                      coil_shift[i] : 1'b0;
              end
            end
          end
          else if (req_num == HR_ERR_NUM && !map_req.write)
          begin
            nxt_cur.rsp.data = {8'h00, cur_ff.err};
          end
          else if (req_num == HR_INDEX_NUM)
          begin
            if (map_req.write)
            begin
              nxt_cur.index = map_req.wdata;
            end
            nxt_cur.rsp.data = map_req.write ? map_req.wdata : cur_ff.index;
          end
          else if (req_num == HR_CTW_NUM)
          begin
            if (map_req.write)
            begin
              nxt_cur.drive_control_word = map_req.wdata;
            end
            nxt_cur.rsp.data = map_req.write ? map_req.wdata : cur_ff.drive_control_word;
          end
          else if (req_num == HR_REF_NUM)
          begin
            if (map_req.write)
            begin
              nxt_cur.ref_val = map_req.wdata;
            end
            nxt_cur.rsp.data = map_req.write ? map_req.wdata :
                               cur_ff.ref_val;
          end
          else if (req_num == HR_STW_NUM && !map_req.write)
          begin
            nxt_cur.rsp.data = stw_word;
          end
          else if (req_num == HR_MAV_NUM && !map_req.write)
          begin
            nxt_cur.rsp.data = mav_word;
          end
          else if (param_hit)
          begin
            // Answer is deferred until the parameter store replies
            nxt_cur.rsp.valid = 1'b0;
            nxt_cur.state = ST_PARAM;
            nxt_cur.preq.valid = 1'b1;
            nxt_cur.preq.write = map_req.write;
            nxt_cur.preq.to_nvm = cur_ff.store;
            nxt_cur.preq.number = 13'((param_off / HR_PARAM_STEP) +
                                      17'h00001);
            nxt_cur.preq.index = cur_ff.index;
            nxt_cur.preq.wdata = map_req.wdata;
          end
          else
          begin
            nxt_cur.rsp.exception = 1'b1;
            nxt_cur.rsp.code = ERR_INVALID_ADDR;
            nxt_cur.err = ERR_INVALID_ADDR;
          end
        end
      end
      ST_PARAM:
      begin
        nxt_cur.state = ST_WAIT;
        if (param_rsp.done)
        begin
          nxt_cur.state = ST_IDLE;
        end
        if (param_rsp.done)
        begin
          nxt_cur.rsp.valid = 1'b1;
          nxt_cur.rsp.exception = param_rsp.error;
          nxt_cur.rsp.code = param_rsp.error ? param_rsp.code : 8'h00;
          nxt_cur.rsp.data = param_rsp.rdata;
          if (param_rsp.error)
          begin
            nxt_cur.err = param_rsp.code;
          end
        end
      end
      ST_WAIT:
      begin
        if (param_rsp.done)
        begin
          nxt_cur.state = ST_IDLE;
          nxt_cur.rsp.valid = 1'b1;
          nxt_cur.rsp.exception = param_rsp.error;
          nxt_cur.rsp.code = param_rsp.error ? param_rsp.code : 8'h00;
          nxt_cur.rsp.data = param_rsp.rdata;
          if (param_rsp.error)
          begin
            nxt_cur.err = param_rsp.code;
          end
        end
      end
      default:
      begin
        nxt_cur.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      cur_ff <= '{state: ST_IDLE, drive_control_word: CTW_RESET, ref_val: REF_RESET,
                  store: 1'b0, index: INDEX_RESET, err: ERR_RESET,
                  rsp: '0, preq: '0};
    end
    else
    begin
      cur_ff <= nxt_cur;
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  assign map_req_ready = (cur_ff.state == ST_IDLE);
  assign map_rsp = cur_ff.rsp;
  assign param_req = cur_ff.preq;
  assign bus_reference = cur_ff.ref_val;
  assign store_to_nvm = cur_ff.store;

  // Stop and brake requests are active when their coil is 0
  always_comb
  begin
    drive_cmd.preset_ref = cur_ff.drive_control_word[1:0];
    drive_cmd.dc_brake = ~cur_ff.drive_control_word[2];
    drive_cmd.coast_stop = ~cur_ff.drive_control_word[3];
    drive_cmd.quick_stop = ~cur_ff.drive_control_word[4];
    drive_cmd.freeze_freq = ~cur_ff.drive_control_word[5];
    drive_cmd.start = cur_ff.drive_control_word[6];
    drive_cmd.reset = cur_ff.drive_control_word[7];
    drive_cmd.jog = cur_ff.drive_control_word[8];
    drive_cmd.ramp2 = cur_ff.drive_control_word[9];
    drive_cmd.data_valid = cur_ff.drive_control_word[10];
    drive_cmd.relay1_on = cur_ff.drive_control_word[11];
    drive_cmd.relay2_on = cur_ff.drive_control_word[12];
    drive_cmd.setup_sel = cur_ff.drive_control_word[14:13];
    drive_cmd.reversing = cur_ff.drive_control_word[15];
  end

endmodule : drive_fieldbus_data_map

`default_nettype wire

// File: dv/drive_map_props.sv
// Checker of the drive data map ports
`timescale 1ns/1ps
`default_nettype none
module drive_map_props (
  input wire logic clk_sys,
  input wire logic rst,
  input wire drive_map_pkg::map_req_type map_req,
  input wire logic map_req_ready,
  input wire drive_map_pkg::map_rsp_type map_rsp,
  input wire drive_map_pkg::param_req_type param_req,
  input wire drive_map_pkg::param_rsp_type param_rsp,
  input wire drive_map_pkg::drive_state_type drive_state,
  input wire logic closed_loop,
  input wire logic [15:0] output_freq,
  input wire logic [15:0] feedback_value,
  input wire drive_map_pkg::drive_cmd_type drive_cmd,
  input wire logic [15:0] bus_reference,
  input wire logic store_to_nvm
);
  import drive_map_pkg::*;
  logic tk;
  logic rd;
  logic wr;
  logic [11:0] s;
  logic [15:0] drive_status_word;
  assign tk = map_req.valid && map_req_ready;
  assign rd = tk && map_req.holding && !map_req.write;
  assign wr = tk && map_req.holding && map_req.write;
  assign s = drive_state;
  // Unused status bits must read low
  assign drive_status_word = {s[0], s[1], s[2], 1'b0, s[3], s[4], s[5], s[6], s[7],
    3'b000, s[8], s[9], s[10], s[11]};
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  //////////////////////
  property p_stw;
    rd && map_req.addr == 16'hC417 |=> map_rsp.valid
      && map_rsp.data == $past(drive_status_word);
  endproperty
  a_stw: assert property (p_stw)
    else $error("status word read wrong");
  property p_mav;
    rd && map_req.addr == 16'hC421 |=> map_rsp.data
      == $past(closed_loop ? feedback_value : output_freq);
  endproperty
  a_mav: assert property (p_mav)
    else $error("actual value read wrong");
  property p_ctw;
    wr && map_req.addr == 16'hC34F |=> drive_cmd.start
      == $past(map_req.wdata[6]) && drive_cmd.coast_stop
      == !$past(map_req.wdata[3]);
  endproperty
  a_ctw: assert property (p_ctw)
    else $error("control word decode wrong");
  property p_ref;
    wr && map_req.addr == 16'hC359 |=> bus_reference
      == $past(map_req.wdata);
  endproperty
  a_ref: assert property (p_ref)
    else $error("reference not stored");
  property p_store;
    tk && !map_req.holding && map_req.write && map_req.addr == 16'h0040
      && map_req.count == 5'h01 |=> store_to_nvm == $past(map_req.wdata[0]);
  endproperty
  a_store: assert property (p_store)
    else $error("store target not stored");
  property p_bad;
    tk && !map_req.holding && map_req.addr == 16'h0041 |=> map_rsp.valid
      && map_rsp.exception && map_rsp.code == ERR_INVALID_ADDR;
  endproperty
  a_bad: assert property (p_bad)
    else $error("reserved coil not refused");
  property p_param;
    rd && map_req.addr == 16'h03E7 |=> param_req.valid
      && param_req.number == 13'h0064 && !map_req_ready;
  endproperty
  a_param: assert property (p_param)
    else $error("parameter request wrong");
  property p_done;
    param_rsp.done && !map_req_ready |=> map_rsp.valid && map_req_ready;
  endproperty
  a_done: assert property (p_done)
    else $error("parameter answer missing");
endmodule : drive_map_props
bind drive_fieldbus_data_map drive_map_props props_u (.clk_sys, .rst,
  .map_req, .map_req_ready, .map_rsp, .param_req, .param_rsp, .drive_state,
  .closed_loop, .output_freq, .feedback_value, .drive_cmd, .bus_reference,
  .store_to_nvm);
`default_nettype wire

// File: dv/param_store.sv
// Parameter store model behind the data map
`timescale 1ns/1ps
`default_nettype none
module param_store (
  input wire logic clk_sys,
  input wire logic rst,
  input wire drive_map_pkg::param_req_type param_req,
  input wire logic [3:0] delay,
  input wire logic fail,
  output drive_map_pkg::param_rsp_type param_rsp
);
  import drive_map_pkg::*;
  logic [15:0] mem [0:15];
  logic [3:0] cnt_ff;
  logic hit;
  assign hit = param_req.valid ? delay == 4'h0 : cnt_ff == 4'h1;
  always_ff @(posedge clk_sys)
  begin
    param_rsp.done <= 1'b0;
    // Read data is not held once answered, so it toggles
    param_rsp.rdata <= rst ? 16'h0000 : ~param_rsp.rdata;
    if (rst)
      cnt_ff <= 4'h0;
    else if (param_req.valid)
      cnt_ff <= delay;
    else if (cnt_ff != 4'h0)
      cnt_ff <= cnt_ff - 4'h1;
    if (!rst && hit)
    begin
      param_rsp.done <= 1'b1;
      param_rsp.error <= fail;
      param_rsp.code <= fail ? 8'h02 : 8'h00;
      param_rsp.rdata <= mem[param_req.number[3:0]];
      if (param_req.write && !fail)
        mem[param_req.number[3:0]] <= param_req.wdata;
    end
  end
endmodule : param_store
`default_nettype wire

// File: dv/drive_fieldbus_data_map_tb.sv
// Self-checking bench for the drive data map
`timescale 1ns/1ps
`default_nettype none
module drive_fieldbus_data_map_tb;
  import drive_map_pkg::*;
  logic clk_sys;
  logic rst;
  map_req_type map_req;
  logic map_req_ready;
  map_rsp_type map_rsp;
  param_req_type param_req;
  param_rsp_type param_rsp;
  drive_state_type drive_state;
  logic closed_loop;
  logic [15:0] output_freq;
  logic [15:0] feedback_value;
  drive_cmd_type drive_cmd;
  logic [15:0] bus_reference;
  logic store_to_nvm;
  logic [3:0] delay;
  logic fail;
  map_rsp_type rsp;
  int failures;
  int n_compared;
  drive_fieldbus_data_map dut_u (.clk_sys, .rst, .map_req, .map_req_ready,
    .map_rsp, .param_req, .param_rsp, .drive_state, .closed_loop,
    .output_freq, .feedback_value, .drive_cmd, .bus_reference,
    .store_to_nvm);
  param_store store_u (.clk_sys, .rst, .param_req, .delay, .fail,
    .param_rsp);
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  //////////////////////
  task automatic test_done;
    if (failures == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  task automatic cmp(input logic [24:0] got, input logic [24:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : cmp
  task automatic xfer(input logic h, input logic w, input logic [15:0] a,
    input logic [4:0] n, input logic [15:0] d);
    int i;
    i = 0;
    while (map_req_ready !== 1'b1 && i < 40)
    begin
      @(negedge clk_sys);
      i++;
    end
    map_req = '{1'b1, h, w, a, n, d};
    @(negedge clk_sys);
    map_req.valid = 1'b0;
    while (map_rsp.valid !== 1'b1 && i < 40)
    begin
      @(negedge clk_sys);
      i++;
    end
    if (i >= 40)
    begin
      failures++;
      test_done();
    end
    rsp = map_rsp;
    @(negedge clk_sys);
  endtask : xfer
  task automatic rd(input logic h, input logic [15:0] a,
    input logic [4:0] n, input logic [15:0] e);
    xfer(h, 1'b0, a, n, 16'h0000);
    cmp({rsp.exception, rsp.code, rsp.data}, {9'h000, e});
  endtask : rd
  task automatic wr(input logic h, input logic [15:0] a,
    input logic [4:0] n, input logic [15:0] d);
    xfer(h, 1'b1, a, n, d);
    cmp({rsp.exception, rsp.code, 16'h0000}, 25'h0000000);
  endtask : wr
  task automatic bad(input logic h, input logic w, input logic [15:0] a,
    input logic [4:0] n);
    xfer(h, w, a, n, 16'h0000);
    cmp({rsp.exception, rsp.code, 16'h0000},
      {1'b1, ERR_INVALID_ADDR, 16'h0000});
  endtask : bad
  //////////////////////
  task automatic t_reset;
    rd(1'b1, 16'hC34F, 5'h00, 16'h0000);
    rd(1'b1, 16'h0008, 5'h00, 16'h0000);
    rd(1'b1, 16'h0006, 5'h00, 16'h0000);
    cmp({24'h000000, drive_cmd.coast_stop}, 25'h0000001);
  endtask : t_reset
  task automatic t_status;
    drive_state = 12'hFFF;
    rd(1'b1, 16'hC417, 5'h00, 16'hEF8F);
    rd(1'b0, 16'h0020, 5'h10, 16'hEF8F);
    rd(1'b0, 16'h0020, 5'h04, 16'h000F);
    drive_state = 12'h801;
    rd(1'b0, 16'h002F, 5'h01, 16'h0001);
    rd(1'b1, 16'hC417, 5'h00, 16'h8001);
    rd(1'b0, 16'h0030, 5'h10, 16'h1357);
    closed_loop = 1'b1;
    rd(1'b1, 16'hC421, 5'h00, 16'h2468);
  endtask : t_status
  task automatic t_control;
    wr(1'b1, 16'hC34F, 5'h00, 16'h8041);
    cmp({9'h000, drive_cmd}, 25'h0007E01);
    rd(1'b0, 16'h0000, 5'h10, 16'h8041);
    wr(1'b0, 16'h0006, 5'h01, 16'h0000);
    rd(1'b1, 16'hC34F, 5'h00, 16'h8001);
    wr(1'b1, 16'hC34F, 5'h00, 16'h7FBE);
    cmp({9'h000, drive_cmd}, 25'h00081FE);
    wr(1'b1, 16'hC359, 5'h00, 16'h5AA5);
    cmp({9'h000, bus_reference}, 25'h0005AA5);
    wr(1'b0, 16'h0010, 5'h10, 16'hA55A);
    cmp({9'h000, bus_reference}, 25'h000A55A);
    rd(1'b1, 16'hC359, 5'h00, 16'hA55A);
  endtask : t_control
  task automatic t_refuse;
    bad(1'b0, 1'b0, 16'h0041, 5'h01);
    bad(1'b0, 1'b0, 16'h0000, 5'h11);
    bad(1'b0, 1'b1, 16'h001E, 5'h05);
    rd(1'b1, 16'hC359, 5'h00, 16'hA55A);
    bad(1'b1, 1'b1, 16'hC417, 5'h00);
    bad(1'b1, 1'b1, 16'h0006, 5'h00);
    bad(1'b1, 1'b0, 16'h0000, 5'h00);
    rd(1'b1, 16'h0006, 5'h00, 16'h0040);
  endtask : t_refuse
  task automatic t_param;
    wr(1'b0, 16'h0040, 5'h01, 16'h0001);
    cmp({24'h000000, store_to_nvm}, 25'h0000001);
    rd(1'b0, 16'h0040, 5'h01, 16'h0001);
    wr(1'b1, 16'h0008, 5'h00, 16'h0003);
    delay = 4'h3;
    wr(1'b1, 16'h03E7, 5'h00, 16'h0055);
    cmp({9'h000, param_req.index}, 25'h0000003);
    cmp({11'h000, param_req.to_nvm, param_req.number}, 25'h0002064);
    cmp({8'h00, param_req.write, param_req.wdata}, 25'h0010055);
    delay = 4'h0;
    wr(1'b1, 16'hC345, 5'h00, 16'h0077);
    rd(1'b1, 16'h03E7, 5'h00, 16'h0055);
    rd(1'b1, 16'hC345, 5'h00, 16'h0077);
    fail = 1'b1;
    xfer(1'b1, 1'b0, 16'h03E7, 5'h00, 16'h0000);
    cmp({rsp.exception, rsp.code, 16'h0000}, 25'h1020000);
    fail = 1'b0;
    rd(1'b1, 16'h0006, 5'h00, 16'h0002);
    wr(1'b0, 16'h0040, 5'h01, 16'h0000);
    rd(1'b1, 16'h03E7, 5'h00, 16'h0055);
    cmp({11'h000, param_req.to_nvm, param_req.number}, 25'h0000064);
  endtask : t_param
  initial
  begin
    failures = 0;
    n_compared = 0;
    rst = 1'b1;
    map_req = '0;
    drive_state = '0;
    closed_loop = 1'b0;
    output_freq = 16'h1357;
    feedback_value = 16'h2468;
    delay = 4'h0;
    fail = 1'b0;
    repeat (16) @(negedge clk_sys);
    rst = 1'b0;
    t_reset();
    t_status();
    t_control();
    t_refuse();
    t_param();
    test_done();
  end
endmodule : drive_fieldbus_data_map_tb
`default_nettype wire
